// ===== verilog/emb_pkg.sv
`default_nettype none

package emb_pkg;

  // Register offsets on the plain register port.
  localparam int unsigned REG_AW = 4;
  localparam logic [REG_AW-1:0] CTRL_OFF = 4'h0;
  localparam logic [REG_AW-1:0] RDTIM_OFF = 4'h4;
  localparam logic [REG_AW-1:0] WRTIM_OFF = 4'h8;
  localparam logic [REG_AW-1:0] STAT_OFF = 4'hC;

  // Control register field positions.
  localparam int unsigned WMODE_BIT = 19;
  localparam int unsigned PGS_LSB = 16;
  localparam int unsigned PGS_W = 3;
  localparam int unsigned AWAIT_BIT = 15;
  localparam int unsigned SPLIT_BIT = 14;
  localparam int unsigned SWAIT_BIT = 13;
  localparam int unsigned WREN_BIT = 12;
  localparam int unsigned WTIM_BIT = 11;
  localparam int unsigned WRAP_BIT = 10;
  localparam int unsigned WPOL_BIT = 9;

  localparam logic [31:0] CTRL_RST = 32'h000030D2;
  localparam logic [31:0] CTRL_WMASK = 32'h000FFF7F;

  // Timing register fields: setup cycles and data phase cycles.
  localparam int unsigned TIM_FW = 4;
  localparam int unsigned SET_LSB = 0;
  localparam int unsigned DST_LSB = 8;
  localparam logic [31:0] TIM_RST = 32'h00000F0F;
  localparam logic [31:0] TIM_WMASK = 32'h00000F0F;

  // Status register fields.
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_STALL_BIT = 1;
  localparam int unsigned STAT_CNT_LSB = 8;
  localparam int unsigned STAT_CNT_W = 8;

  localparam int unsigned BEAT_BYTES = 4;
  localparam int unsigned PAGE_MAX_W = 12;

  localparam logic [PGS_W-1:0] PGS_NONE = 3'h0;
  localparam logic [PGS_W-1:0] PGS_128 = 3'h1;
  localparam logic [PGS_W-1:0] PGS_256 = 3'h2;
  localparam logic [PGS_W-1:0] PGS_512 = 3'h3;
  localparam logic [PGS_W-1:0] PGS_1024 = 3'h4;

  typedef enum logic [1:0] {
    EMB_IDLE,
    EMB_SETUP,
    EMB_DATA,
    EMB_GAP
  } emb_state_t;

  // Page size in bytes; zero means no splitting, reserved codes too.
  function automatic logic [PAGE_MAX_W-1:0] page_bytes(
      input logic [PGS_W-1:0] code);
    unique case (code)
      PGS_128: page_bytes = 12'h080;
      PGS_256: page_bytes = 12'h100;
      PGS_512: page_bytes = 12'h200;
      PGS_1024: page_bytes = 12'h400;
      default: page_bytes = 12'h000;
    endcase
  endfunction : page_bytes

endpackage : emb_pkg

`default_nettype wire

// ===== verilog/emb_wait_qual.sv
`default_nettype none

module emb_wait_qual (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic wait_pin_i,
  input wire logic sync_mode_i,
  input wire logic async_en_i,
  input wire logic sync_en_i,
  input wire logic polarity_i,
  input wire logic timing_i,
  output logic stall_o
);
  import emb_pkg::*;

  typedef struct packed {
    logic [2:0] sync;
    logic lvl;
    logic lvl_dly;
  } emb_wq_t;

  emb_wq_t q, d;
  logic active;
  logic active_dly;
  logic enabled;

  always_comb begin
    d = q;
    d.sync = {q.sync[1:0], wait_pin_i};
    if (q.sync[1] == q.sync[2]) begin
      d.lvl = q.sync[2];
    end
    d.lvl_dly = q.lvl;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '{sync: 3'h7, lvl: 1'b1, lvl_dly: 1'b1};
    end else begin
      q <= d;
    end
  end

  // Asynchronous transfers always treat the pin as active low.
  always_comb begin
    active = (sync_mode_i && polarity_i) ? q.lvl : !q.lvl;
    active_dly = (sync_mode_i && polarity_i) ? q.lvl_dly : !q.lvl_dly;
    enabled = sync_mode_i ? sync_en_i : async_en_i;
    // An early warning stalls from the cycle after it is seen.
    if (sync_mode_i && !timing_i) begin
      stall_o = enabled && active_dly;
    end else begin
      stall_o = enabled && active;
    end
  end

endmodule : emb_wait_qual

`default_nettype wire

// ===== verilog/emb_bank_ctrl.sv
// Contract
// - Write mode bit clear gives asynchronous writes, set gives synchronous; resets clear.
// - Page size code 0 none, 1..4 give 128..1024 bytes, others reserved.
// - Synchronous access crossing a selected page boundary is split into accesses.
// - Asynchronous wait enable decides if the wait pin counts; resets clear.
// - Split timing bit set uses write timing for writes, read timing otherwise.
// - Synchronous wait enable decides if the wait pin counts; resets set.
// - Wait timing bit: 0 pin warns a cycle early, 1 during wait.
// - Wrapped burst split into two linear accesses unless wrap allow set.
// - Upper twelve control bits read zero and change nothing.
// - Wait polarity bit: 0 active low, 1 active high, synchronous mode.
//
// Chosen here: the address map and the plain strobed port.
`default_nettype none

module emb_bank_ctrl #(
  parameter int unsigned ADDR_W = 26,
  parameter int unsigned LEN_W = 5
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [emb_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  input wire logic sys_start_i,
  input wire logic sys_we_i,
  input wire logic sys_wrap_i,
  input wire logic sys_read_sync_i,
  input wire logic [ADDR_W-1:0] sys_addr_i,
  input wire logic [LEN_W-1:0] sys_len_i,
  input wire logic [31:0] sys_wdata_i,
  output logic sys_busy_o,
  output logic sys_beat_o,
  output logic [31:0] sys_rdata_o,
  output logic sys_done_o,
  output logic sys_err_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_wait_i,
  output logic mem_cs_n_o,
  output logic mem_we_n_o,
  output logic mem_oe_n_o,
  output logic mem_sync_o
);
  import emb_pkg::*;

  if (ADDR_W < PAGE_MAX_W || ADDR_W > 32) begin : g_chk_addr
    $error("emb_bank_ctrl: ADDR_W must lie in 12..32");
  end
  if (LEN_W < 1 || LEN_W > 8) begin : g_chk_len
    $error("emb_bank_ctrl: LEN_W must lie in 1..8");
  end
  // Addresses step by whole words with the two low bits held at zero.
  if (BEAT_BYTES != 4) begin : g_chk_beat
    $error("emb_bank_ctrl: BEAT_BYTES must be 4");
  end
  // The largest page must fit the page arithmetic width.
  if (PAGE_MAX_W < 11) begin : g_chk_page
    $error("emb_bank_ctrl: PAGE_MAX_W must be at least 11");
  end

  typedef struct packed {
    emb_state_t state;
    logic [31:0] ctrl;
    logic [31:0] rdtim;
    logic [31:0] wrtim;
    logic [31:0] reg_rdata;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0] left;
    logic [LEN_W-1:0] len;
    logic [TIM_FW-1:0] cnt;
    logic we;
    logic wrap;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic done;
    logic err;
    logic [STAT_CNT_W-1:0] splits;
  } emb_state_q_t;

  emb_state_q_t q, d;

  logic stall;
  logic sync_mode;
  logic [31:0] tim;
  logic [31:0] start_tim;
  logic [TIM_FW-1:0] setup_cyc;
  logic [TIM_FW-1:0] data_cyc;
  logic [ADDR_W-1:0] lin_next;
  logic [ADDR_W-1:0] wrap_mask;
  logic [ADDR_W-1:0] next_addr;
  logic [ADDR_W-1:0] page_mask;
  logic [PAGE_MAX_W-1:0] page_sz;
  logic cross_page;
  logic wraps;
  logic beat;

  // Data phase length; writes keep at least two cycles so that the
  // registered write data settles before the strobe ends.
  function automatic logic [TIM_FW-1:0] data_reload(
      input logic is_write, input logic [TIM_FW-1:0] cyc);
    if (is_write && cyc == '0) begin
      data_reload = 4'h1;
    end else begin
      data_reload = cyc;
    end
  endfunction : data_reload

  // Separate write timing only applies to writes with the split bit set.
  function automatic logic [31:0] sel_timing(input logic is_write,
      input logic split, input logic [31:0] rd_tim,
      input logic [31:0] wr_tim);
    if (is_write && split) begin
      sel_timing = wr_tim;
    end else begin
      sel_timing = rd_tim;
    end
  endfunction : sel_timing

  // Merge writable bits only; the upper reserved bits stay zero.
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] val, input logic [31:0] mask);
    merge = (old & ~mask) | (val & mask);
  endfunction : merge

  emb_wait_qual u_wait (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .wait_pin_i(mem_wait_i),
    .sync_mode_i(sync_mode),
    .async_en_i(q.ctrl[AWAIT_BIT]),
    .sync_en_i(q.ctrl[SWAIT_BIT]),
    .polarity_i(q.ctrl[WPOL_BIT]),
    .timing_i(q.ctrl[WTIM_BIT]),
    .stall_o(stall)
  );

  always_comb begin
    // Writes follow the write mode bit; reads follow the burst setting.
    sync_mode = q.we ? q.ctrl[WMODE_BIT] : sys_read_sync_i;
    tim = sel_timing(q.we, q.ctrl[SPLIT_BIT], q.rdtim, q.wrtim);
    // The transfer being started is not yet latched, so look at its inputs.
    start_tim = sel_timing(sys_we_i, q.ctrl[SPLIT_BIT], q.rdtim, q.wrtim);
    setup_cyc = tim[SET_LSB +: TIM_FW];
    data_cyc = tim[DST_LSB +: TIM_FW];
    lin_next = q.addr + ADDR_W'(BEAT_BYTES);
    wrap_mask = ADDR_W'({q.len, 2'b00}) - ADDR_W'(1);
    wraps = q.wrap && ((lin_next & wrap_mask) == '0);
    if (q.wrap) begin
      next_addr = (q.addr & ~wrap_mask) | (lin_next & wrap_mask);
    end else begin
      next_addr = lin_next;
    end
    // Reserved page codes give a zero size, so they never split.
    page_sz = page_bytes(q.ctrl[PGS_LSB +: PGS_W]);
    page_mask = ADDR_W'(page_sz) - ADDR_W'(1);
    cross_page = sync_mode && (page_sz != '0)
        && ((next_addr & page_mask) == '0);
    beat = (q.state == EMB_DATA) && !stall && (q.cnt == '0);
  end

  always_comb begin
    d = q;
    d.reg_rdata = '0;
    d.done = 1'b0;
    d.err = 1'b0;
    d.wdata = sys_wdata_i;

    if (reg_we_i) begin
      unique case (reg_addr_i)
        CTRL_OFF: d.ctrl = merge(q.ctrl, reg_wdata_i, CTRL_WMASK);
        RDTIM_OFF: d.rdtim = merge(q.rdtim, reg_wdata_i, TIM_WMASK);
        WRTIM_OFF: d.wrtim = merge(q.wrtim, reg_wdata_i, TIM_WMASK);
        STAT_OFF: d.splits = '0;
        default: ;
      endcase
    end

    if (reg_re_i) begin
      unique case (reg_addr_i)
        CTRL_OFF: d.reg_rdata = q.ctrl;
        RDTIM_OFF: d.reg_rdata = q.rdtim;
        WRTIM_OFF: d.reg_rdata = q.wrtim;
        STAT_OFF: begin
          d.reg_rdata[STAT_BUSY_BIT] = (q.state != EMB_IDLE);
          d.reg_rdata[STAT_STALL_BIT] = stall && (q.state == EMB_DATA);
          d.reg_rdata[STAT_CNT_LSB +: STAT_CNT_W] = q.splits;
        end
        default: d.reg_rdata = '0;
      endcase
    end

    unique case (q.state)
      EMB_IDLE: begin
        if (sys_start_i) begin
          d.addr = {sys_addr_i[ADDR_W-1:2], 2'b00};
          d.we = sys_we_i;
          d.wrap = sys_wrap_i;
          d.len = (sys_len_i == '0) ? LEN_W'(1) : sys_len_i;
          d.left = (sys_len_i == '0) ? LEN_W'(1) : sys_len_i;
          if (sys_we_i && !q.ctrl[WREN_BIT]) begin
            d.done = 1'b1;
            d.err = 1'b1;
          end else begin
            d.state = EMB_SETUP;
            d.cnt = start_tim[SET_LSB +: TIM_FW];
          end
        end
      end
      EMB_SETUP: begin
        if (q.cnt == '0) begin
          d.state = EMB_DATA;
          d.cnt = data_reload(q.we, data_cyc);
        end else begin
          d.cnt = q.cnt - TIM_FW'(1);
        end
      end
      EMB_DATA: begin
        if (stall) begin
          d.cnt = q.cnt;
        end else if (q.cnt != '0) begin
          d.cnt = q.cnt - TIM_FW'(1);
        end else begin
          if (!q.we) begin
            d.rdata = mem_rdata_i;
          end
          d.left = q.left - LEN_W'(1);
          d.addr = next_addr;
          if (q.left == LEN_W'(1)) begin
            d.state = EMB_IDLE;
            d.done = 1'b1;
          end else if (cross_page || (wraps && !q.ctrl[WRAP_BIT])) begin
            d.state = EMB_GAP;
            d.splits = q.splits + STAT_CNT_W'(1);
          end else begin
            d.cnt = data_reload(q.we, data_cyc);
          end
        end
      end
      // The gap drops chip select so the memory sees a fresh access.
      EMB_GAP: begin
        d.state = EMB_SETUP;
        d.cnt = setup_cyc;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '{state: EMB_IDLE, ctrl: CTRL_RST, rdtim: TIM_RST,
             wrtim: TIM_RST, default: '0};
    end else begin
      q <= d;
    end
  end

  always_comb begin
    reg_rdata_o = q.reg_rdata;
    sys_busy_o = (q.state != EMB_IDLE);
    sys_beat_o = beat;
    sys_rdata_o = q.rdata;
    sys_done_o = q.done;
    sys_err_o = q.err;
    mem_addr_o = q.addr;
    mem_wdata_o = q.wdata;
    mem_cs_n_o = !((q.state == EMB_SETUP) || (q.state == EMB_DATA));
    // The write strobe can only rise for a write that was permitted.
    mem_we_n_o = !(q.we && (q.state == EMB_DATA));
    mem_oe_n_o = !(!q.we && (q.state == EMB_DATA));
    mem_sync_o = sync_mode && !mem_cs_n_o;
  end

endmodule : emb_bank_ctrl

`default_nettype wire

// ===== testbench/emb_mem_model.sv
`default_nettype none

module emb_mem_model (
  input wire logic sys_clk_i,
  input wire logic cs_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [25:0] addr_i,
  input wire logic pol_i,
  input wire logic [7:0] hold_i,
  output logic [31:0] rdata_o,
  output logic wait_o,
  output int wr_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q = 8'h00;
  initial begin
    rdata_o = 32'h0;
    wr_cnt_o = 0;
  end
  // Released data lines toggle so a stale word never passes for a read.
  always @(posedge sys_clk_i) begin
    cnt_q <= cs_n_i ? 8'h00 : cnt_q + 8'h01;
    rdata_o <= oe_n_i ? ~rdata_o : {6'h00, addr_i} ^ 32'h5A5A0000;
    if (!we_n_i) begin
      wr_cnt_o <= wr_cnt_o + 1;
    end
  end
  // Wait is active for the first hold_i cycles of each selection.
  assign wait_o = (!cs_n_i && cnt_q < hold_i) ? pol_i : !pol_i;
endmodule : emb_mem_model

`default_nettype wire

// ===== testbench/emb_bank_asserts.sv
`default_nettype none

module emb_bank_asserts
  import emb_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [emb_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic sys_busy_o,
  input wire logic sys_beat_o,
  input wire logic sys_done_o,
  input wire logic sys_err_o,
  input wire logic mem_wait_i,
  input wire logic mem_cs_n_o,
  input wire logic mem_we_n_o,
  input wire logic mem_oe_n_o,
  input wire logic mem_sync_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ctrl_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (reg_we_i && reg_addr_i == CTRL_OFF) begin
      ctrl_q <= (reg_wdata_i & CTRL_WMASK) | (CTRL_RST & ~CTRL_WMASK);
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  chk_rd_upper_zero: assert property (
    $past(reg_re_i) |-> reg_rdata_o[31:20] == 12'h000) else $error("upper");
  chk_rd_ctrl_value: assert property (
    $past(reg_re_i) && $past(reg_addr_i) == CTRL_OFF |-> reg_rdata_o == ctrl_q)
    else $error("ctrl readback");
  chk_no_write_cycle: assert property (
    !ctrl_q[WREN_BIT] |-> mem_we_n_o) else $error("write while off");
  chk_err_without_cs: assert property (
    sys_err_o |-> sys_done_o && $past(mem_cs_n_o) && $past(mem_cs_n_o, 2))
    else $error("refused write");
  chk_async_wait_stall: assert property (
    (!mem_wait_i)[*6] ##0 (ctrl_q[AWAIT_BIT] && !mem_sync_o) |-> !sys_beat_o)
    else $error("async stall");
  chk_sync_wait_stall: assert property (
    mem_wait_i[*7] ##0 (ctrl_q[SWAIT_BIT] && ctrl_q[WPOL_BIT] && mem_sync_o)
    |-> !sys_beat_o) else $error("sync stall");
  chk_we_oe_apart: assert property (
    !(!mem_we_n_o && !mem_oe_n_o)) else $error("we and oe");
  chk_beat_in_cs: assert property (
    sys_beat_o |-> sys_busy_o && !mem_cs_n_o) else $error("beat");
  chk_done_after_beat: assert property (
    sys_done_o && !sys_err_o |-> $past(sys_beat_o)) else $error("done");
endmodule : emb_bank_asserts

bind emb_bank_ctrl emb_bank_asserts u_emb_bank_asserts (.sys_clk_i, .nrst_i,
  .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .sys_busy_o,
  .sys_beat_o, .sys_done_o, .sys_err_o, .mem_wait_i, .mem_cs_n_o, .mem_we_n_o,
  .mem_oe_n_o, .mem_sync_o);

`default_nettype wire

// ===== testbench/tb_top.sv
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import emb_pkg::*;
  logic sys_clk_i = 1'h0, nrst_i = 1'h0, reg_we_i = 1'h0, reg_re_i = 1'h0;
  logic sys_start_i = 1'h0, sys_we_i = 1'h0, sys_wrap_i = 1'h0;
  logic sys_read_sync_i = 1'h0, pol = 1'h0, ev, ss;
  logic sys_busy_o, sys_beat_o, sys_done_o, sys_err_o, mem_wait_i;
  logic mem_cs_n_o, mem_we_n_o, mem_oe_n_o, mem_sync_o;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0, sys_wdata_i = 32'hA5A50000, d;
  logic [31:0] reg_rdata_o, sys_rdata_o, mem_wdata_o, mem_rdata_i;
  logic [25:0] sys_addr_i = 26'h0, mem_addr_o;
  logic [4:0] sys_len_i = 5'h1;
  logic [7:0] hold = 8'h00;
  int miscompares = 0, comparisons = 0, wr_cnt, cyc, nb, c0, n0;

  emb_bank_ctrl u_emb_bank_ctrl (.sys_clk_i, .nrst_i, .reg_addr_i,
    .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .sys_start_i, .sys_we_i,
    .sys_wrap_i, .sys_read_sync_i, .sys_addr_i, .sys_len_i, .sys_wdata_i,
    .sys_busy_o, .sys_beat_o, .sys_rdata_o, .sys_done_o, .sys_err_o,
    .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_wait_i, .mem_cs_n_o,
    .mem_we_n_o, .mem_oe_n_o, .mem_sync_o);
  emb_mem_model u_emb_mem_model (.sys_clk_i, .cs_n_i(mem_cs_n_o),
    .we_n_i(mem_we_n_o), .oe_n_i(mem_oe_n_o), .addr_i(mem_addr_o),
    .pol_i(pol), .hold_i(hold), .rdata_o(mem_rdata_i), .wait_o(mem_wait_i),
    .wr_cnt_o(wr_cnt));

  always #5 sys_clk_i = ~sys_clk_i;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic give_verdict;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    reg_we_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge sys_clk_i);
    reg_we_i <= 1'h0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    reg_re_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_re_i <= 1'h0;
    @(negedge sys_clk_i);
    d = reg_rdata_o;
  endtask : rd

  task automatic xfer(input logic w, input logic wp, input logic s,
                      input logic [25:0] a, input logic [4:0] n);
    @(posedge sys_clk_i);
    sys_start_i <= 1'h1;
    sys_we_i <= w;
    sys_wrap_i <= wp;
    sys_read_sync_i <= s;
    sys_addr_i <= a;
    sys_len_i <= n;
    @(posedge sys_clk_i);
    sys_start_i <= 1'h0;
    cyc = 1;
    nb = 0;
    ss = 1'h0;
    while (sys_done_o !== 1'h1 && cyc < 900) begin
      @(negedge sys_clk_i);
      cyc++;
      nb += int'(sys_beat_o);
      ss |= mem_sync_o;
    end
    chk(cyc < 900, 1);
    ev = sys_err_o;
  endtask : xfer

  task automatic t_regs;
    rd(CTRL_OFF);
    chk(d, 32'h000030D2);
    wr(CTRL_OFF, 32'hFFFFFFFF);
    rd(CTRL_OFF);
    chk(d, 32'h000FFFFF);
    wr(CTRL_OFF, 32'h0);
    rd(CTRL_OFF);
    chk(d, 32'h00000080);
  endtask : t_regs

  task automatic t_timing;
    wr(RDTIM_OFF, 32'h00000101);
    wr(WRTIM_OFF, 32'h00000808);
    wr(CTRL_OFF, CTRL_RST);
    xfer(1'h1, 1'h0, 1'h0, 26'h40, 5'h1);
    c0 = cyc;
    chk(ss, 0);
    chk(mem_wdata_o, 32'hA5A50000);
    wr(CTRL_OFF, CTRL_RST | 32'h00004000);
    xfer(1'h1, 1'h0, 1'h0, 26'h40, 5'h1);
    chk(cyc - c0, 14);
    xfer(1'h0, 1'h0, 1'h0, 26'h40, 5'h1);
    chk(sys_rdata_o, 32'h5A5A0040);
    chk(mem_addr_o, 26'h44);
    wr(CTRL_OFF, CTRL_RST | 32'h00080000);
    xfer(1'h1, 1'h0, 1'h0, 26'h40, 5'h1);
    chk(ss, 1);
  endtask : t_timing

  task automatic t_split(input logic [31:0] c, input logic wp,
                         input logic s, input logic [25:0] a, input int e);
    wr(CTRL_OFF, c);
    wr(STAT_OFF, 32'h0);
    xfer(1'h0, wp, s, a, 5'h4);
    rd(STAT_OFF);
    chk(d[15:8], e);
    chk(nb, 4);
  endtask : t_split

  task automatic t_wren;
    wr(CTRL_OFF, CTRL_RST & ~32'h00001000);
    n0 = wr_cnt;
    xfer(1'h1, 1'h0, 1'h0, 26'h20, 5'h1);
    chk(ev, 1);
    chk(wr_cnt - n0, 0);
    wr(CTRL_OFF, CTRL_RST);
    xfer(1'h1, 1'h0, 1'h0, 26'h20, 5'h1);
    chk(ev, 0);
    chk(wr_cnt > n0, 1);
  endtask : t_wren

  task automatic w_run(input logic [31:0] c, input logic s, input logic p,
                       input logic [7:0] h);
    wr(CTRL_OFF, c);
    pol <= p;
    hold <= h;
    xfer(1'h0, 1'h0, s, 26'h10, 5'h1);
  endtask : w_run

  task automatic t_wait;
    wr(RDTIM_OFF, TIM_RST);
    w_run(CTRL_RST, 1'h0, 1'h0, 8'h00);
    c0 = cyc;
    w_run(CTRL_RST, 1'h0, 1'h0, 8'h1C);
    chk(cyc, c0);
    w_run(CTRL_RST | 32'h00008000, 1'h0, 1'h0, 8'h1C);
    chk(cyc > c0, 1);
    w_run(CTRL_RST, 1'h1, 1'h0, 8'h00);
    c0 = cyc;
    w_run(CTRL_RST, 1'h1, 1'h0, 8'h1C);
    chk(cyc > c0, 1);
    w_run(CTRL_RST | 32'h00000200, 1'h1, 1'h1, 8'h1C);
    chk(cyc > c0, 1);
    n0 = cyc;
    w_run(CTRL_RST | 32'h00000A00, 1'h1, 1'h1, 8'h1C);
    chk(cyc > c0, 1);
    chk(cyc, n0 - 1);
    w_run(CTRL_RST & ~32'h00002000, 1'h1, 1'h0, 8'h1C);
    chk(cyc, c0);
  endtask : t_wait

  initial begin
    #500000;
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge sys_clk_i);
    nrst_i <= 1'h1;
    t_regs();
    t_timing();
    for (int c = 0; c < 8; c++) begin
      t_split(CTRL_RST | (32'(c) << PGS_LSB), 1'h0, 1'h1,
              (c > 0 && c < 5) ? (26'h40 << c) - 26'h8 : 26'h78,
              (c > 0 && c < 5) ? 1 : 0);
    end
    t_split(CTRL_RST | 32'h00010000, 1'h0, 1'h0, 26'h78, 0);
    t_split(CTRL_RST, 1'h1, 1'h0, 26'h8, 1);
    t_split(CTRL_RST | 32'h00000400, 1'h1, 1'h0, 26'h8, 0);
    t_wren();
    t_wait();
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
